/* File: pwm_pkg.sv */
// Constants, register map and field layout shared by the pulse width modulator files
package pwm_pkg;
   // ------------------------------------------------------------
   // Structure
   // ------------------------------------------------------------
   localparam int CH_NUM = 4;
   localparam int DUTY_W = 16;
   localparam int PRESC_W = 12;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 250;
   localparam int BASE_CLK_MHZ = 100;
   localparam int ACC_W = 9;
   localparam logic [ACC_W:0] SYS_STEP = (ACC_W + 1)'(SYS_CLK_MHZ);
   localparam logic [ACC_W:0] BASE_STEP = (ACC_W + 1)'(BASE_CLK_MHZ);
   localparam int DIV_MAX = 4096;
   localparam int TCNT_MAX = 65535;
   // ------------------------------------------------------------
   // Register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CH_BASE_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] PRESC_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h44;
   localparam logic [ADDR_W-1:0] CTR_LOW_OFS = 8'h48;
   localparam logic [ADDR_W-1:0] CTR_HIGH_OFS = 8'h4c;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h50;
   localparam int CH_IDX_LSB = 4;
   localparam int FLD_LSB = 2;
   localparam logic [1:0] FLD_DUTY = 2'h0;
   localparam logic [1:0] FLD_TCNT = 2'h1;
   localparam logic [1:0] FLD_POL = 2'h2;
   // Enable register: bits 3:0 run, bits 11:8 restart strobes
   localparam int EN_RUN_LSB = 0;
   localparam int EN_RESTART_LSB = 8;
   // Status register: 3:0 levels, 11:8 period-done flags, 27:16 prescaler count
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_DONE_LSB = 8;
   localparam int STAT_PRESC_LSB = 16;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
   localparam logic [DUTY_W-1:0] TCNT_RST = 16'hffff;
   localparam logic [PRESC_W-1:0] PRESC_RST = 12'h000;
   localparam logic [CH_NUM-1:0] CH_BITS_RST = 4'h0;
endpackage

/* File: pwm_prescaler.sv */
// Prescaler that turns base ticks into divided count ticks
`timescale 1ns/10ps
`default_nettype none

module pwm_prescaler (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic base_tick_i,
   input wire logic [pwm_pkg::PRESC_W-1:0] factor_m1_i,
   output logic divided_count_clock_o,
   output logic [pwm_pkg::PRESC_W-1:0] count_o
);
   logic [pwm_pkg::PRESC_W-1:0] cnt_r;
   logic tick_r;
   wire at_end;
   wire [pwm_pkg::PRESC_W-1:0] cnt_nxt;

   // Compare with >= so that shrinking the factor never strands the count
   assign at_end = cnt_r >= factor_m1_i;
   assign cnt_nxt = !base_tick_i ? cnt_r : (at_end ? '0 : cnt_r + 1'b1);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= base_tick_i & at_end;
      end
   end

   assign divided_count_clock_o = tick_r;
   assign count_o = cnt_r;
endmodule // pwm_prescaler

`default_nettype wire

/* File: pwm_channel.sv */
// One modulator channel: counter, shadowed settings and output stage
`timescale 1ns/10ps
`default_nettype none

module pwm_channel (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic count_tick_i,
   input wire logic enable_i,
   input wire logic restart_i,
   input wire logic [pwm_pkg::DUTY_W-1:0] duty_i,
   input wire logic [pwm_pkg::DUTY_W-1:0] tcnt_i,
   input wire logic pol_i,
   output logic modulated_output_o,
   output logic [pwm_pkg::DUTY_W-1:0] counter_o,
   output logic period_end_o
);
   logic [pwm_pkg::DUTY_W-1:0] ctr_r;
   logic [pwm_pkg::DUTY_W-1:0] duty_act_r;
   logic [pwm_pkg::DUTY_W-1:0] tcnt_act_r;
   logic out_r;
   logic end_r;
   wire wrap;
   wire boundary;
   wire level;
   wire [pwm_pkg::DUTY_W-1:0] ctr_nxt;

   assign wrap = ctr_r >= tcnt_act_r;
   assign boundary = count_tick_i & wrap;
   // Settings are shadowed so a write mid-period cannot cut a pulse short
   assign ctr_nxt = (!enable_i || restart_i) ? '0 :
                    (!count_tick_i ? ctr_r : (wrap ? '0 : ctr_r + 1'b1));
   assign level = !enable_i ? 1'b0 :
                  (duty_act_r == '0) ? 1'b0 :
                  (duty_act_r >= tcnt_act_r) ? 1'b1 :
                  (ctr_r < duty_act_r);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctr_r <= '0;
         duty_act_r <= pwm_pkg::DUTY_RST;
         tcnt_act_r <= pwm_pkg::TCNT_RST;
         out_r <= 1'b0;
         end_r <= 1'b0;
      end else begin
         ctr_r <= ctr_nxt;
         if (!enable_i || restart_i || boundary) begin
            duty_act_r <= duty_i;
            tcnt_act_r <= tcnt_i;
         end
         out_r <= level ^ pol_i;
         end_r <= enable_i & boundary;
      end
   end

   assign modulated_output_o = out_r;
   assign counter_o = ctr_r;
   assign period_end_o = end_r;
endmodule // pwm_channel

`default_nettype wire

/* File: four_channel_pwm.sv */
// Four-channel pulse width modulator top with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Four channels, each with its own duty, period and polarity.
// - All channel timing derives from a 100 MHz base tick.
// - Prescaler divides the base tick by a programmable factor up to 4096.
// - Channel counters advance on the divided count tick, not the base tick.
// - Counter values read back in pairs; writes there change nothing.
// - Each channel has a terminal count up to 65535 setting its period.
// - Each channel has a duty value setting its high time per period.
// - Duty of zero keeps the output low for the whole period.
// - Duty at or above terminal count keeps the output high.
// - Polarity invert setting flips the channel output.
// - Period is set by the terminal count and the shared prescaler factor, apart from duty.
module four_channel_pwm (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [pwm_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [pwm_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [pwm_pkg::BE_W-1:0] avs_byteenable_i,
   output logic [pwm_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [pwm_pkg::CH_NUM-1:0] modulated_output_o
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Byte-lane merge of a write into a stored word
   function automatic logic [pwm_pkg::DATA_W-1:0] be_merge(
      input logic [pwm_pkg::DATA_W-1:0] old_v,
      input logic [pwm_pkg::DATA_W-1:0] new_v,
      input logic [pwm_pkg::BE_W-1:0] be);
      logic [pwm_pkg::DATA_W-1:0] res;
      res = old_v;
      for (int b = 0; b < pwm_pkg::BE_W; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Zero-extend a narrow field into a bus word
   function automatic logic [pwm_pkg::DATA_W-1:0] widen16(
      input logic [pwm_pkg::DUTY_W-1:0] v);
      return {{(pwm_pkg::DATA_W - pwm_pkg::DUTY_W){1'b0}}, v};
   endfunction

   // ------------------------------------------------------------
   // Base tick generation
   // ------------------------------------------------------------
   // The system clock is not an integer multiple of the base rate, so a
   // phase accumulator spreads the ticks; the average rate is exact,
   // the spacing alternates between two and three system cycles.
   logic [pwm_pkg::ACC_W-1:0] base_acc_r;
   logic base_tick_r;
   wire [pwm_pkg::ACC_W:0] acc_sum;
   wire acc_wrap;
   wire [pwm_pkg::ACC_W:0] acc_left;
   wire [pwm_pkg::ACC_W-1:0] base_acc_nxt;

   assign acc_sum = {1'b0, base_acc_r} + pwm_pkg::BASE_STEP;
   assign acc_wrap = acc_sum >= pwm_pkg::SYS_STEP;
   assign acc_left = acc_wrap ? acc_sum - pwm_pkg::SYS_STEP : acc_sum;
   assign base_acc_nxt = acc_left[pwm_pkg::ACC_W-1:0];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         base_acc_r <= '0;
         base_tick_r <= 1'b0;
      end else begin
         base_acc_r <= base_acc_nxt;
         base_tick_r <= acc_wrap;
      end
   end

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   // Every access waits exactly one cycle; read data is captured in the
   // first cycle and presented when waitrequest drops.
   logic ack_r;
   logic [pwm_pkg::DATA_W-1:0] rdata_r;
   wire req;
   wire first_cycle;
   wire wr_fire;

   assign req = avs_read_i | avs_write_i;
   assign first_cycle = req & ~ack_r;
   assign wr_fire = avs_write_i & ack_r;
   assign avs_waitrequest_o = req & ~ack_r;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire ch_hit;
   wire [1:0] ch_idx;
   wire [1:0] fld;
   wire hit_duty;
   wire hit_tcnt;
   wire hit_pol;
   wire hit_presc;
   wire hit_enable;
   wire hit_ctr_low;
   wire hit_ctr_high;
   wire hit_status;
   wire [pwm_pkg::ADDR_W-1:0] ch_ofs;

   assign ch_ofs = avs_address_i - pwm_pkg::CH_BASE_OFS;
   assign ch_hit = avs_address_i < pwm_pkg::PRESC_OFS;
   assign ch_idx = ch_ofs[pwm_pkg::CH_IDX_LSB +: 2];
   assign fld = ch_ofs[pwm_pkg::FLD_LSB +: 2];
   assign hit_duty = ch_hit && (fld == pwm_pkg::FLD_DUTY);
   assign hit_tcnt = ch_hit && (fld == pwm_pkg::FLD_TCNT);
   assign hit_pol = ch_hit && (fld == pwm_pkg::FLD_POL);
   assign hit_presc = avs_address_i == pwm_pkg::PRESC_OFS;
   assign hit_enable = avs_address_i == pwm_pkg::ENABLE_OFS;
   assign hit_ctr_low = avs_address_i == pwm_pkg::CTR_LOW_OFS;
   assign hit_ctr_high = avs_address_i == pwm_pkg::CTR_HIGH_OFS;
   assign hit_status = avs_address_i == pwm_pkg::STATUS_OFS;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [pwm_pkg::DUTY_W-1:0] duty_r [pwm_pkg::CH_NUM];
   logic [pwm_pkg::DUTY_W-1:0] tcnt_r [pwm_pkg::CH_NUM];
   logic [pwm_pkg::CH_NUM-1:0] pol_r;
   logic [pwm_pkg::CH_NUM-1:0] run_r;
   logic [pwm_pkg::CH_NUM-1:0] restart_r;
   logic [pwm_pkg::PRESC_W-1:0] presc_r;
   wire [pwm_pkg::DATA_W-1:0] duty_word;
   wire [pwm_pkg::DATA_W-1:0] tcnt_word;
   wire [pwm_pkg::DATA_W-1:0] pol_word;
   wire [pwm_pkg::DATA_W-1:0] presc_word;
   wire [pwm_pkg::DATA_W-1:0] enable_word;
   wire [pwm_pkg::DATA_W-1:0] enable_old;

   assign duty_word = be_merge(widen16(duty_r[ch_idx]), avs_writedata_i, avs_byteenable_i);
   assign tcnt_word = be_merge(widen16(tcnt_r[ch_idx]), avs_writedata_i, avs_byteenable_i);
   assign pol_word = be_merge({{(pwm_pkg::DATA_W - 1){1'b0}}, pol_r[ch_idx]},
                              avs_writedata_i, avs_byteenable_i);
   assign presc_word = be_merge({{(pwm_pkg::DATA_W - pwm_pkg::PRESC_W){1'b0}}, presc_r},
                                avs_writedata_i, avs_byteenable_i);
   assign enable_old = {{(pwm_pkg::DATA_W - pwm_pkg::CH_NUM){1'b0}}, run_r};
   assign enable_word = be_merge(enable_old, avs_writedata_i, avs_byteenable_i);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         for (int c = 0; c < pwm_pkg::CH_NUM; c++) begin
            duty_r[c] <= pwm_pkg::DUTY_RST;
            tcnt_r[c] <= pwm_pkg::TCNT_RST;
         end
      end else if (wr_fire) begin
         if (hit_duty) begin
            duty_r[ch_idx] <= duty_word[pwm_pkg::DUTY_W-1:0];
         end
         if (hit_tcnt) begin
            tcnt_r[ch_idx] <= tcnt_word[pwm_pkg::DUTY_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pol_r <= pwm_pkg::CH_BITS_RST;
         run_r <= pwm_pkg::CH_BITS_RST;
         presc_r <= pwm_pkg::PRESC_RST;
      end else if (wr_fire) begin
         if (hit_pol) begin
            pol_r[ch_idx] <= pol_word[0];
         end
         if (hit_presc) begin
            presc_r <= presc_word[pwm_pkg::PRESC_W-1:0];
         end
         if (hit_enable) begin
            run_r <= enable_word[pwm_pkg::EN_RUN_LSB +: pwm_pkg::CH_NUM];
         end
      end
   end

   // Restart strobes self-clear; they read back as zero
   wire [pwm_pkg::CH_NUM-1:0] restart_nxt;
   wire restart_lane;

   assign restart_lane = avs_byteenable_i[pwm_pkg::EN_RESTART_LSB / 8];
   assign restart_nxt = (wr_fire && hit_enable && restart_lane) ?
                        avs_writedata_i[pwm_pkg::EN_RESTART_LSB +: pwm_pkg::CH_NUM] : '0;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         restart_r <= pwm_pkg::CH_BITS_RST;
      end else begin
         restart_r <= restart_nxt;
      end
   end

   // ------------------------------------------------------------
   // Prescaler and channels
   // ------------------------------------------------------------
   wire divided_count_clock;
   wire [pwm_pkg::PRESC_W-1:0] presc_count;
   wire [pwm_pkg::DUTY_W-1:0] ctr [pwm_pkg::CH_NUM];
   wire [pwm_pkg::CH_NUM-1:0] period_end;

   // Factor register holds divide ratio minus one, so 4096 fits 12 bits
   pwm_prescaler u_prescaler (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .base_tick_i(base_tick_r),
      .factor_m1_i(presc_r),
      .divided_count_clock_o(divided_count_clock),
      .count_o(presc_count)
   );

   for (genvar g = 0; g < pwm_pkg::CH_NUM; g++) begin : g_ch
      pwm_channel u_channel (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .count_tick_i(divided_count_clock),
         .enable_i(run_r[g]),
         .restart_i(restart_r[g]),
         .duty_i(duty_r[g]),
         .tcnt_i(tcnt_r[g]),
         .pol_i(pol_r[g]),
         .modulated_output_o(modulated_output_o[g]),
         .counter_o(ctr[g]),
         .period_end_o(period_end[g])
      );
   end

   // ------------------------------------------------------------
   // Period-done flags
   // ------------------------------------------------------------
   // Write one to clear; a boundary in the clearing cycle keeps its flag
   logic [pwm_pkg::CH_NUM-1:0] done_r;
   wire [pwm_pkg::CH_NUM-1:0] done_clr;
   wire [pwm_pkg::CH_NUM-1:0] done_nxt;
   wire done_lane;

   assign done_lane = avs_byteenable_i[pwm_pkg::STAT_DONE_LSB / 8];
   assign done_clr = (wr_fire && hit_status && done_lane) ?
                     avs_writedata_i[pwm_pkg::STAT_DONE_LSB +: pwm_pkg::CH_NUM] : '0;
   assign done_nxt = (done_r & ~done_clr) | period_end;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         done_r <= pwm_pkg::CH_BITS_RST;
      end else begin
         done_r <= done_nxt;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   wire [pwm_pkg::DATA_W-1:0] rd_ch;
   wire [pwm_pkg::DATA_W-1:0] rd_ctr_low;
   wire [pwm_pkg::DATA_W-1:0] rd_ctr_high;
   wire [pwm_pkg::DATA_W-1:0] rd_status;
   wire [pwm_pkg::DATA_W-1:0] rd_mux;

   assign rd_ch = hit_duty ? widen16(duty_r[ch_idx]) :
                  hit_tcnt ? widen16(tcnt_r[ch_idx]) :
                  hit_pol ? {{(pwm_pkg::DATA_W - 1){1'b0}}, pol_r[ch_idx]} : '0;
   // Counters are only read; no write path reaches them
   assign rd_ctr_low = {ctr[1], ctr[0]};
   assign rd_ctr_high = {ctr[3], ctr[2]};
   assign rd_status = {{(pwm_pkg::DATA_W - pwm_pkg::STAT_PRESC_LSB - pwm_pkg::PRESC_W){1'b0}},
                       presc_count,
                       {(pwm_pkg::STAT_PRESC_LSB - pwm_pkg::STAT_DONE_LSB
                         - pwm_pkg::CH_NUM){1'b0}},
                       done_r,
                       {(pwm_pkg::STAT_DONE_LSB - pwm_pkg::CH_NUM){1'b0}},
                       modulated_output_o};
   assign rd_mux = ch_hit ? rd_ch :
                   hit_presc ? {{(pwm_pkg::DATA_W - pwm_pkg::PRESC_W){1'b0}}, presc_r} :
                   hit_enable ? enable_old :
                   hit_ctr_low ? rd_ctr_low :
                   hit_ctr_high ? rd_ctr_high :
                   hit_status ? rd_status : '0;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= first_cycle;
         if (first_cycle && avs_read_i) begin
            rdata_r <= rd_mux;
         end
      end
   end

   assign avs_readdata_o = rdata_r;
endmodule // four_channel_pwm

`default_nettype wire

/* File: four_channel_pwm_assertions.sv */
// Concurrent checks on the register bus and outputs of the modulator
`timescale 1ns/10ps
`default_nettype none
module four_channel_pwm_checker (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [pwm_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [pwm_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [pwm_pkg::BE_W-1:0] avs_byteenable_i,
   input wire logic [pwm_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [pwm_pkg::CH_NUM-1:0] modulated_output_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ----------------------------------------
   // Shadow of run bits and channel 0 polarity
   // ----------------------------------------
   logic [pwm_pkg::CH_NUM-1:0] run_r;
   logic pol0_r;
   wire logic req = avs_read_i | avs_write_i;
   wire logic rd_ack = avs_read_i & ~avs_waitrequest_o;
   wire logic wr_ack = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   wire logic hole = avs_address_i == 8'h54 ||
      (avs_address_i < pwm_pkg::PRESC_OFS && avs_address_i[3:2] == 2'h3);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         run_r <= '0;
         pol0_r <= 1'b0;
      end else begin
         if (wr_ack && avs_address_i == pwm_pkg::ENABLE_OFS) run_r <= avs_writedata_i[3:0];
         if (wr_ack && avs_address_i == 8'h08) pol0_r <= avs_writedata_i[0];
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   wait_first_a: assert property ($rose(req) |-> avs_waitrequest_o)
      else $error("waitrequest low in first request cycle");
   wait_once_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held beyond one cycle");
   wait_idle_a: assert property (!req |-> !avs_waitrequest_o)
      else $error("waitrequest high while idle");
   hole_read_a: assert property (rd_ack && hole |-> avs_readdata_o == '0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!(avs_read_i && avs_waitrequest_o)
      |=> $stable(avs_readdata_o))
      else $error("read data moved without a read");
   enable_rd_a: assert property (rd_ack && avs_address_i == pwm_pkg::ENABLE_OFS
      |-> avs_readdata_o == 32'(run_r))
      else $error("enable readback wrong");
   status_lvl_a: assert property (rd_ack && avs_address_i == pwm_pkg::STATUS_OFS
      |-> avs_readdata_o[3:0] == $past(modulated_output_o))
      else $error("status levels differ from outputs");
   idle_pol_a: assert property (!run_r[0] && !$past(run_r[0]) && !$past(run_r[0], 2)
      && $stable(pol0_r) |-> modulated_output_o[0] == pol0_r)
      else $error("stopped channel not at polarity level");
endmodule // four_channel_pwm_checker
`default_nettype wire

/* File: pwm_load_model.sv */
// Off-chip load: counts high cycles and rising edges of each output
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
   input wire logic clk_i,
   input wire logic clear_i,
   input wire logic measure_i,
   input wire logic [pwm_pkg::CH_NUM-1:0] level_i,
   output logic [pwm_pkg::CH_NUM-1:0][15:0] high_cnt_o,
   output logic [pwm_pkg::CH_NUM-1:0][7:0] rise_cnt_o
);
   logic [pwm_pkg::CH_NUM-1:0] last_r;
   always_ff @(posedge clk_i) begin
      last_r <= level_i;
      for (int n = 0; n < pwm_pkg::CH_NUM; n++) begin
         if (clear_i) begin
            high_cnt_o[n] <= '0;
            rise_cnt_o[n] <= '0;
         end else if (measure_i) begin
            high_cnt_o[n] <= high_cnt_o[n] + 16'(level_i[n]);
            rise_cnt_o[n] <= rise_cnt_o[n] + 8'(level_i[n] & ~last_r[n]);
         end
      end
   end
endmodule // pwm_load_model
`default_nettype wire

/* File: four_channel_pwm_tb_top.sv */
// Self-checking bench for the four-channel modulator
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module four_channel_pwm_tb_top;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] rdat;
   logic wreq;
   logic [3:0] mout;
   logic clr = 1'b0;
   logic meas = 1'b0;
   logic [3:0][15:0] high_cnt;
   logic [3:0][7:0] rise_cnt;
   logic [31:0] rv;
   int err_total = 0;
   int checks_done = 0;
   four_channel_pwm i_four_channel_pwm (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .modulated_output_o(mout));
   pwm_load_model i_pwm_load_model (.clk_i(clk_i), .clear_i(clr), .measure_i(meas),
      .level_i(mout), .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Bus and measurement tasks
   // ----------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
      @(posedge clk_i);
      adr <= a;
      wdat <= d;
      be <= b;
      rd <= ~w;
      wr <= w;
      // Waitrequest and read data both taken at the rising edge
      @(posedge clk_i);
      while (wreq !== 1'b0) @(posedge clk_i);
      rv = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0, 4'hf);
      `CHK(nm, e, rv)
   endtask
   // Window spans whole waveform periods, so counts are exact despite tick jitter
   task automatic meas_chk(input int w, input logic [3:0][15:0] eh, input logic [3:0][7:0] er);
      repeat (200) @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      meas <= 1'b1;
      repeat (w) @(posedge clk_i);
      meas <= 1'b0;
      @(posedge clk_i);
      for (int n = 0; n < 4; n++) begin
         `CHK("high time", eh[n], high_cnt[n])
         `CHK("rising edges", er[n], rise_cnt[n])
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      `CHK("outputs after reset", 4'h0, mout)
      rchk(8'h00, 32'h0, "duty reset");
      rchk(8'h04, 32'h0000ffff, "period reset");
      rchk(8'h08, 32'h0, "polarity reset");
      rchk(pwm_pkg::PRESC_OFS, 32'h0, "prescaler reset");
      rchk(pwm_pkg::ENABLE_OFS, 32'h0, "enable reset");
      rchk(8'h0c, 32'h0, "channel hole");
      wreg(8'h54, 32'hffffffff);
      rchk(8'h54, 32'h0, "unmapped");
      bus(1'b1, 8'h30, 32'h0001ffff, 4'h1);
      rchk(8'h30, 32'h000000ff, "duty lane merge");
      wreg(pwm_pkg::PRESC_OFS, 32'hffffffff);
      rchk(pwm_pkg::PRESC_OFS, 32'h00000fff, "max divider");
      wreg(8'h14, 32'h0001ffff);
      rchk(8'h14, 32'h0000ffff, "max terminal count");
   endtask
   task automatic t_channels();
      for (int n = 0; n < 4; n++) begin
         wreg(8'(n * 16 + 4), 32'd4);
      end
      wreg(pwm_pkg::PRESC_OFS, 32'h0);
      wreg(8'h00, 32'd2);
      wreg(8'h20, 32'd4);
      wreg(8'h30, 32'd1);
      wreg(8'h38, 32'd1);
      repeat (4) @(posedge clk_i);
      `CHK("stopped outputs", 4'h8, mout)
      wreg(pwm_pkg::ENABLE_OFS, 32'h0000000f);
      meas_chk(50, {16'd40, 16'd50, 16'd0, 16'd20}, {8'd4, 8'd0, 8'd0, 8'd4});
      wreg(pwm_pkg::CTR_LOW_OFS, 32'h00080008);
      bus(1'b0, pwm_pkg::CTR_LOW_OFS, 32'h0, 4'hf);
      `CHK("counter pair low", 1'b1, rv[15:0] <= 16'd4 && rv[31:16] <= 16'd4)
      bus(1'b0, pwm_pkg::CTR_HIGH_OFS, 32'h0, 4'hf);
      `CHK("counter pair high", 1'b1, rv[15:0] <= 16'd4 && rv[31:16] <= 16'd4)
   endtask
   task automatic t_prescale();
      wreg(pwm_pkg::PRESC_OFS, 32'd2);
      meas_chk(75, {16'd60, 16'd75, 16'd0, 16'd30}, {8'd2, 8'd0, 8'd0, 8'd2});
   endtask
   task automatic t_period();
      wreg(pwm_pkg::PRESC_OFS, 32'h0);
      wreg(8'h04, 32'd6);
      meas_chk(175, {16'd140, 16'd175, 16'd0, 16'd50}, {8'd14, 8'd0, 8'd0, 8'd10});
   endtask
   task automatic t_idle();
      wreg(pwm_pkg::ENABLE_OFS, 32'h0);
      wreg(8'h38, 32'h0);
      wreg(8'h08, 32'h1);
      repeat (4) @(posedge clk_i);
      `CHK("stopped at polarity", 4'h1, mout)
      bus(1'b0, pwm_pkg::STATUS_OFS, 32'h0, 4'hf);
      `CHK("status levels", 4'h1, rv[3:0])
      `CHK("period done flags", 4'hf, rv[11:8])
      `CHK("prescaler count", 12'h000, rv[27:16])
      wreg(pwm_pkg::STATUS_OFS, 32'h00000f00);
      rchk(pwm_pkg::STATUS_OFS, 32'h00000001, "done flags cleared");
      rchk(pwm_pkg::CTR_LOW_OFS, 32'h0, "stopped counters low");
      rchk(pwm_pkg::CTR_HIGH_OFS, 32'h0, "stopped counters high");
   endtask
   // Huge divider keeps channel 0 far from its boundary
   task automatic t_restart();
      wreg(pwm_pkg::PRESC_OFS, 32'h00000fff);
      wreg(pwm_pkg::ENABLE_OFS, 32'h00000001);
      wreg(8'h00, 32'h0);
      repeat (4) @(posedge clk_i);
      `CHK("duty held to boundary", 1'b0, mout[0])
      wreg(pwm_pkg::ENABLE_OFS, 32'h00000101);
      repeat (4) @(posedge clk_i);
      `CHK("duty loaded on restart", 1'b1, mout[0])
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_channels();
      t_prescale();
      t_period();
      t_idle();
      t_restart();
      end_sim();
   end
   // Whole run needs about a thousand cycles
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
endmodule // four_channel_pwm_tb_top
bind four_channel_pwm four_channel_pwm_checker i_four_channel_pwm_checker (
   .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .modulated_output_o(modulated_output_o));
`default_nettype wire
